// file: verilog/bridge_adc_pkg.sv
// shared constants for the bridge converter control and readout block
`default_nettype none
package bridge_adc_pkg;
    // core clock
    localparam int CLK_PERIOD_NS = 4;

    // conversion rates selected by the rate-select pin
    localparam int SLOW_RATE_SPS = 10;
    localparam int FAST_RATE_SPS = 80;
    localparam int NS_PER_S = 1000000000;
    localparam int SLOW_PERIOD_NS = NS_PER_S / SLOW_RATE_SPS;
    localparam int FAST_PERIOD_NS = NS_PER_S / FAST_RATE_SPS;
    localparam int SLOW_PERIOD_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FAST_PERIOD_CYCLES = FAST_PERIOD_NS / CLK_PERIOD_NS;

    // shift clock held high this long requests standby
    localparam int STANDBY_HOLD_NS = 10000;
    localparam int STANDBY_HOLD_CYCLES =
        (STANDBY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // result format
    localparam int RESULT_BITS = 18;
    localparam int COUNT_BITS = 5;
    localparam logic [4:0] FORCE_HIGH_COUNT = 5'h12;
    localparam logic [4:0] IDLE_COUNT = 5'h13;

    // register port
    localparam int ADDR_BITS = 3;
    localparam int DATA_BITS = 8;
    localparam logic [2:0] STATUS_OFFSET = 3'h0;
    localparam logic [2:0] CLEAR_OFFSET = 3'h1;
    localparam logic [2:0] ENABLE_OFFSET = 3'h2;
    localparam logic [2:0] PINS_OFFSET = 3'h3;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // event bit positions in status, clear and enable
    localparam int EV_READY_BIT = 0;
    localparam int EV_OVERWRITE_BIT = 1;
    localparam int EV_STANDBY_BIT = 2;
    localparam int EV_COUNT = 3;

    // pin state register bit positions
    localparam int PIN_SPEED_BIT = 0;
    localparam int PIN_SHUTDOWN_N_BIT = 1;
    localparam int PIN_STANDBY_BIT = 2;
    localparam int PIN_SINGLE_ENDED_BIT = 3;

    // power modes
    typedef enum logic [0:0] {MODE_RUN, MODE_STANDBY} power_mode_t;
    // serial pin roles
    typedef enum logic [1:0] {PIN_HIGH, PIN_READY, PIN_DATA} pin_role_t;
endpackage
`default_nettype wire

// file: verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for a group of slow pin levels
module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_reg <= RESET_VALUE;
            sync_reg <= RESET_VALUE;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

// file: verilog/conv_timer.sv
`timescale 1ns/100ps
`default_nettype none
// paces conversions; one pulse per finished conversion
module conv_timer #(
    parameter int SLOW_CYCLES = bridge_adc_pkg::SLOW_PERIOD_CYCLES,
    parameter int FAST_CYCLES = bridge_adc_pkg::FAST_PERIOD_CYCLES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic fast_i,
    output logic done_o
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic done_reg;
    logic done_next;
    logic [31:0] last;

    // a rate change mid-period ends the current period early at worst
    always_comb begin
        last = fast_i ? 32'(FAST_CYCLES - 1) : 32'(SLOW_CYCLES - 1);
        count_next = count_reg;
        done_next = 1'b0;
        if (!run_i) begin
            count_next = '0;
        end else if (count_reg >= last) begin
            count_next = '0;
            done_next = 1'b1;
        end else begin
            count_next = count_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;
endmodule
`default_nettype wire

// file: verilog/bridge_adc_readout.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_adc_readout #(
    parameter int SLOW_CYCLES = bridge_adc_pkg::SLOW_PERIOD_CYCLES,
    parameter int FAST_CYCLES = bridge_adc_pkg::FAST_PERIOD_CYCLES,
    parameter int STANDBY_CYCLES = bridge_adc_pkg::STANDBY_HOLD_CYCLES
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic SPEED_I,
    input wire logic SHUTDOWN_N_I,
    input wire logic SHIFT_CLK_I,
    input wire logic SINGLE_ENDED_I,
    input wire logic [bridge_adc_pkg::RESULT_BITS-1:0] CONV_RESULT_I,
    output logic READY_AND_SERIAL_OUT_O,
    output logic BRIDGE_LOW_SIDE_SWITCH_O,
    output logic BRIDGE_LOW_SIDE_SWITCH_OE_O,
    output logic ANALOG_ENABLE_O,
    input wire logic [bridge_adc_pkg::ADDR_BITS-1:0] REG_ADDR_I,
    input wire logic [bridge_adc_pkg::DATA_BITS-1:0] REG_WDATA_I,
    input wire logic REG_WRITE_I,
    input wire logic REG_READ_I,
    output logic [bridge_adc_pkg::DATA_BITS-1:0] REG_RDATA_O,
    output logic IRQ_O
);
    localparam int RB = bridge_adc_pkg::RESULT_BITS;
    localparam int CB = bridge_adc_pkg::COUNT_BITS;
    localparam int DB = bridge_adc_pkg::DATA_BITS;
    localparam int EB = bridge_adc_pkg::EV_COUNT;

    // synchronised pins; shutdown_n resets to high so SRST_I alone decides
    logic [3:0] pins_sync;
    logic speed;
    logic shutdown_n;
    logic shift_level;
    logic single_ended;
    logic core_rst;

    pin_sync #(
        .WIDTH(4),
        .RESET_VALUE(4'h2)
    ) u_pin_sync (
        .clk_i(CLOCK_I),
        .srst_i(SRST_I),
        .async_i({SINGLE_ENDED_I, SHIFT_CLK_I, SHUTDOWN_N_I, SPEED_I}),
        .sync_o(pins_sync)
    );

    assign speed = pins_sync[0];
    assign shutdown_n = pins_sync[1];
    assign shift_level = pins_sync[2];
    assign single_ended = pins_sync[3];
    assign core_rst = SRST_I | ~shutdown_n;

    // shift clock edge finder, reads only the synchronised level
    logic shift_prev_reg;
    logic shift_prev_next;
    logic shift_rise;

    always_comb begin
        shift_prev_next = shift_level;
    end

    always_ff @(posedge CLOCK_I) begin
        if (core_rst) begin
            shift_prev_reg <= 1'b0;
        end else begin
            shift_prev_reg <= shift_prev_next;
        end
    end

    assign shift_rise = shift_level & ~shift_prev_reg;

    // standby detection: shift clock held high for the hold time
    bridge_adc_pkg::power_mode_t mode_reg;
    bridge_adc_pkg::power_mode_t mode_next;
    logic [31:0] hold_reg;
    logic [31:0] hold_next;
    logic standby_event;

    always_comb begin
        mode_next = mode_reg;
        hold_next = hold_reg;
        standby_event = 1'b0;
        unique case (mode_reg)
            bridge_adc_pkg::MODE_RUN: begin
                if (!shift_level) begin
                    hold_next = '0;
                end else if (hold_reg >= 32'(STANDBY_CYCLES - 1)) begin
                    mode_next = bridge_adc_pkg::MODE_STANDBY;
                    standby_event = 1'b1;
                    hold_next = '0;
                end else begin
                    hold_next = hold_reg + 32'h1;
                end
            end
            bridge_adc_pkg::MODE_STANDBY: begin
                // falling shift clock wakes the converter
                if (!shift_level) begin
                    mode_next = bridge_adc_pkg::MODE_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (core_rst) begin
            mode_reg <= bridge_adc_pkg::MODE_RUN;
            hold_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            hold_reg <= hold_next;
        end
    end

    // conversion pacing, stopped in standby and shutdown
    logic running;
    logic conv_done;

    assign running = (mode_reg == bridge_adc_pkg::MODE_RUN);

    conv_timer #(
        .SLOW_CYCLES(SLOW_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) u_conv_timer (
        .clk_i(CLOCK_I),
        .srst_i(core_rst),
        .run_i(running),
        .fast_i(speed),
        .done_o(conv_done)
    );

    // result clamp for single-ended use
    function automatic logic [RB-1:0] clamp_code(
        input logic [RB-1:0] code,
        input logic unipolar
    );
        clamp_code = (unipolar && code[RB-1]) ? '0 : code;
    endfunction

    // serial pin: ready flag, then result bits, then forced high
    bridge_adc_pkg::pin_role_t role_reg;
    bridge_adc_pkg::pin_role_t role_next;
    logic [RB-1:0] data_reg;
    logic [RB-1:0] data_next;
    logic [CB-1:0] count_reg;
    logic [CB-1:0] count_next;
    logic out_reg;
    logic out_next;
    logic overwrite_event;

    // a new result wins over a shift edge in the same cycle
    always_comb begin
        role_next = role_reg;
        data_next = data_reg;
        count_next = count_reg;
        out_next = out_reg;
        overwrite_event = 1'b0;
        if (conv_done) begin
            // unread or partly read data is simply replaced
            overwrite_event = (role_reg == bridge_adc_pkg::PIN_READY) ||
                ((role_reg == bridge_adc_pkg::PIN_DATA) &&
                 (count_reg < 5'(RB)));
            data_next = clamp_code(CONV_RESULT_I, single_ended);
            role_next = bridge_adc_pkg::PIN_READY;
            count_next = '0;
            out_next = 1'b0;
        end else if (!running) begin
            role_next = bridge_adc_pkg::PIN_HIGH;
            out_next = 1'b1;
        end else if (shift_rise) begin
            unique case (role_reg)
                bridge_adc_pkg::PIN_READY,
                bridge_adc_pkg::PIN_DATA: begin
                    if (count_reg < 5'(RB)) begin
                        // msb first, one bit per edge
                        out_next = data_reg[RB-1];
                        data_next = {data_reg[RB-2:0], 1'b0};
                        count_next = count_reg + 5'h1;
                        role_next = bridge_adc_pkg::PIN_DATA;
                    end else begin
                        out_next = 1'b1;
                        count_next = bridge_adc_pkg::IDLE_COUNT;
                        role_next = bridge_adc_pkg::PIN_HIGH;
                    end
                end
                bridge_adc_pkg::PIN_HIGH: begin
                    out_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (core_rst) begin
            role_reg <= bridge_adc_pkg::PIN_HIGH;
            data_reg <= '0;
            count_reg <= bridge_adc_pkg::IDLE_COUNT;
            out_reg <= 1'b1;
        end else begin
            role_reg <= role_next;
            data_reg <= data_next;
            count_reg <= count_next;
            out_reg <= out_next;
        end
    end

    // switch and power outputs follow the conversion state
    logic switch_closed_reg;
    logic switch_closed_next;

    always_comb begin
        switch_closed_next = running;
    end

    always_ff @(posedge CLOCK_I) begin
        if (core_rst) begin
            switch_closed_reg <= 1'b0;
        end else begin
            switch_closed_reg <= switch_closed_next;
        end
    end

    // switch pulls to ground when closed, floats when open
    assign BRIDGE_LOW_SIDE_SWITCH_O = 1'b0;
    assign BRIDGE_LOW_SIDE_SWITCH_OE_O = switch_closed_reg;
    assign ANALOG_ENABLE_O = switch_closed_reg;
    assign READY_AND_SERIAL_OUT_O = out_reg;

    // event status, clear and enable; pins alone configure conversion
    logic [EB-1:0] status_reg;
    logic [EB-1:0] status_next;
    logic [EB-1:0] enable_reg;
    logic [EB-1:0] enable_next;
    logic [DB-1:0] rdata_reg;
    logic [DB-1:0] rdata_next;
    logic [EB-1:0] events;
    logic [EB-1:0] clears;

    // status lives on SRST_I only, so events from before a shutdown are still visible after it
    always_comb begin
        events = '0;
        events[bridge_adc_pkg::EV_READY_BIT] = conv_done & ~core_rst;
        events[bridge_adc_pkg::EV_OVERWRITE_BIT] =
            overwrite_event & ~core_rst;
        events[bridge_adc_pkg::EV_STANDBY_BIT] = standby_event & ~core_rst;
        clears = '0;
        if (REG_WRITE_I && REG_ADDR_I == bridge_adc_pkg::CLEAR_OFFSET) begin
            clears = REG_WDATA_I[EB-1:0];
        end
        // a set in the clearing cycle survives
        status_next = (status_reg & ~clears) | events;
        enable_next = enable_reg;
        if (REG_WRITE_I && REG_ADDR_I == bridge_adc_pkg::ENABLE_OFFSET) begin
            enable_next = REG_WDATA_I[EB-1:0];
        end
        rdata_next = '0;
        if (REG_READ_I) begin
            unique case (REG_ADDR_I)
                bridge_adc_pkg::STATUS_OFFSET:
                    rdata_next[EB-1:0] = status_reg;
                bridge_adc_pkg::ENABLE_OFFSET:
                    rdata_next[EB-1:0] = enable_reg;
                bridge_adc_pkg::PINS_OFFSET: begin
                    rdata_next[bridge_adc_pkg::PIN_SPEED_BIT] = speed;
                    rdata_next[bridge_adc_pkg::PIN_SHUTDOWN_N_BIT] =
                        shutdown_n;
                    rdata_next[bridge_adc_pkg::PIN_STANDBY_BIT] = ~running;
                    rdata_next[bridge_adc_pkg::PIN_SINGLE_ENDED_BIT] =
                        single_ended;
                end
                default: rdata_next = '0; // clear and unmapped read zero
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            status_reg <= bridge_adc_pkg::STATUS_RESET[EB-1:0];
            enable_reg <= bridge_adc_pkg::ENABLE_RESET[EB-1:0];
            rdata_reg <= '0;
        end else begin
            status_reg <= status_next;
            enable_reg <= enable_next;
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA_O = rdata_reg;
    assign IRQ_O = |(status_reg & enable_reg);
endmodule
`default_nettype wire

// file: dv/bridge_adc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_adc_properties #(
    parameter int FAST_CYCLES = 60,
    parameter int STANDBY_CYCLES = 100
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic SPEED_I,
    input wire logic SHUTDOWN_N_I,
    input wire logic SHIFT_CLK_I,
    input wire logic READY_AND_SERIAL_OUT_O,
    input wire logic BRIDGE_LOW_SIDE_SWITCH_O,
    input wire logic BRIDGE_LOW_SIDE_SWITCH_OE_O,
    input wire logic ANALOG_ENABLE_O,
    input wire logic REG_READ_I,
    input wire logic [bridge_adc_pkg::DATA_BITS-1:0] REG_RDATA_O
);
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (SRST_I);
    int hi_reg, hi_next, quiet_reg, quiet_next;
    // run lengths; margins cover the two-flop pin synchronisers
    always_comb begin
        hi_next = (SHIFT_CLK_I && SHUTDOWN_N_I) ? hi_reg + 1 : 0;
        quiet_next = (SPEED_I && SHUTDOWN_N_I && !SHIFT_CLK_I &&
            READY_AND_SERIAL_OUT_O) ? quiet_reg + 1 : 0;
    end
    always_ff @(posedge CLOCK_I) begin
        hi_reg <= SRST_I ? 0 : hi_next;
        quiet_reg <= SRST_I ? 0 : quiet_next;
    end
    a_release_idle: assert property ($fell(SRST_I) |->
        READY_AND_SERIAL_OUT_O && !ANALOG_ENABLE_O)
        else $error("outputs not idle after reset");
    a_shutdown_hold: assert property (!SHUTDOWN_N_I [*6] |->
        !ANALOG_ENABLE_O && READY_AND_SERIAL_OUT_O)
        else $error("converter still active in shutdown");
    a_switch_ground: assert property (
        BRIDGE_LOW_SIDE_SWITCH_O == 1'b0)
        else $error("switch output not at ground level");
    a_switch_follows: assert property (
        BRIDGE_LOW_SIDE_SWITCH_OE_O == ANALOG_ENABLE_O)
        else $error("switch state differs from power state");
    a_standby_entry: assert property (
        hi_reg == STANDBY_CYCLES + 6 |->
        !ANALOG_ENABLE_O && READY_AND_SERIAL_OUT_O)
        else $error("no standby after long shift high");
    a_run_closed: assert property (
        (!SHIFT_CLK_I && SHUTDOWN_N_I) [*8] |->
        ANALOG_ENABLE_O && BRIDGE_LOW_SIDE_SWITCH_OE_O)
        else $error("not running with shift low");
    a_shift_only: assert property (
        (!SHIFT_CLK_I && SHUTDOWN_N_I) [*6] |=>
        !$rose(READY_AND_SERIAL_OUT_O))
        else $error("serial output rose without shift edge");
    a_fast_pace: assert property (
        quiet_reg < FAST_CYCLES + 12)
        else $error("no result within the fast period");
    a_rdata_idle: assert property (
        !REG_READ_I |=> REG_RDATA_O == 8'h00)
        else $error("read data without a read");
endmodule
bind bridge_adc_readout bridge_adc_properties #(
    .FAST_CYCLES(FAST_CYCLES), .STANDBY_CYCLES(STANDBY_CYCLES)
) bridge_adc_properties_i (
    .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .SPEED_I(SPEED_I),
    .SHUTDOWN_N_I(SHUTDOWN_N_I), .SHIFT_CLK_I(SHIFT_CLK_I),
    .READY_AND_SERIAL_OUT_O(READY_AND_SERIAL_OUT_O),
    .BRIDGE_LOW_SIDE_SWITCH_O(BRIDGE_LOW_SIDE_SWITCH_O),
    .BRIDGE_LOW_SIDE_SWITCH_OE_O(BRIDGE_LOW_SIDE_SWITCH_OE_O),
    .ANALOG_ENABLE_O(ANALOG_ENABLE_O), .REG_READ_I(REG_READ_I),
    .REG_RDATA_O(REG_RDATA_O)
);
`default_nettype wire

// file: dv/host_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
    input wire logic serial_i,
    output logic shift_o
);
    // shift clock rests low between frames
    initial shift_o = 1'b0;
    // 32 ns bit periods, sampled just before the next rise
    task automatic shift_bits(input int n, output logic [18:0] bits);
        bits = '0;
        for (int k = 0; k < n; k++) begin
            shift_o = 1'b1;
            #16;
            shift_o = 1'b0;
            #16;
            bits = {bits[17:0], serial_i};
        end
    endtask
    // parking high asks for standby, low wakes
    task automatic park(input logic level);
        shift_o = level;
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int FAST = 400;
    localparam int SLOW = 3200;
    localparam int STBY = 100;
    localparam logic [2:0] ST = bridge_adc_pkg::STATUS_OFFSET;
    localparam logic [2:0] CLR = bridge_adc_pkg::CLEAR_OFFSET;
    localparam logic [2:0] EN = bridge_adc_pkg::ENABLE_OFFSET;
    localparam logic [2:0] PIN = bridge_adc_pkg::PINS_OFFSET;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic speed = 1'b1;
    logic shdn_n = 1'b1;
    logic single = 1'b0;
    logic [17:0] result = 18'h2a5c3;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [18:0] bits;
    logic [17:0] codes [4] = '{18'h2a5c3, 18'h15a3c, 18'h2a5c3, 18'h1ffff};
    logic [17:0] exps [4] = '{18'h2a5c3, 18'h15a3c, 18'h00000, 18'h1ffff};
    wire logic shift, sout, sw, sw_oe, an_en, irq;
    wire logic [7:0] rdata;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int t0;
    int t1;
    always #2 clk = ~clk;
    bridge_adc_readout #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST),
        .STANDBY_CYCLES(STBY)) bridge_adc_readout_i (
        .CLOCK_I(clk), .SRST_I(srst), .SPEED_I(speed),
        .SHUTDOWN_N_I(shdn_n), .SHIFT_CLK_I(shift),
        .SINGLE_ENDED_I(single), .CONV_RESULT_I(result),
        .READY_AND_SERIAL_OUT_O(sout), .BRIDGE_LOW_SIDE_SWITCH_O(sw),
        .BRIDGE_LOW_SIDE_SWITCH_OE_O(sw_oe), .ANALOG_ENABLE_O(an_en),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WRITE_I(wr_en),
        .REG_READ_I(rd_en), .REG_RDATA_O(rdata), .IRQ_O(irq));
    host_link_model host_link_model_i (.serial_i(sout), .shift_o(shift));
    task automatic check_val(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // data stand only in the cycle after the read edge
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check_val("rdata", exp, rdata);
    endtask
    // bounded poll; the cycle stamp gives the conversion pacing
    task automatic wait_ready(output int t);
        // step off the clock edge before the first look at the pin
        #1;
        for (int n = 0; n < 4000 && sout !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        t = cyc;
        check_val("ready", 1'b0, sout);
    endtask
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1;
        check_val("idle", 2'b10, {sout, an_en});
        reg_wr(ST, 8'hff);
        reg_rd(ST, 8'h00);
        reg_rd(3'h5, 8'h00);
        reg_rd(CLR, 8'h00);
        reg_rd(PIN, 8'h03);
        reg_wr(EN, 8'h07);
        reg_rd(EN, 8'h07);
        // frames back to back: codes, clamping and pacing
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            single <= (i > 1);
            result <= codes[i];
            wait_ready(t1);
            if (i == 0) begin
                reg_rd(ST, 8'h01);
                check_val("irq", 1'b1, irq);
            end else
                check_val("period", FAST, t1 - t0);
            t0 = t1;
            host_link_model_i.shift_bits(19, bits);
            check_val("frame", {exps[i], 1'b1}, bits);
        end
        // leave a result unread so the next one replaces it
        @(posedge clk);
        single <= 1'b0;
        result <= 18'h00ff0;
        wait_ready(t0);
        @(posedge clk);
        result <= 18'h3ff00;
        repeat (FAST + 4) @(posedge clk);
        reg_rd(ST, 8'h03);
        host_link_model_i.shift_bits(19, bits);
        check_val("frame", {18'h3ff00, 1'b1}, bits);
        // mask, unmask and clear the interrupt
        reg_wr(EN, 8'h00);
        @(posedge clk);
        #1;
        check_val("irq", 1'b0, irq);
        reg_wr(EN, 8'h07);
        @(posedge clk);
        #1;
        check_val("irq", 1'b1, irq);
        reg_wr(CLR, 8'h07);
        reg_rd(ST, 8'h00);
        check_val("irq", 1'b0, irq);
        // standby must land before the next conversion is due
        host_link_model_i.park(1'b1);
        repeat (STBY + 8) @(posedge clk);
        #1;
        check_val("standby", 3'b100, {sout, an_en, sw_oe});
        reg_rd(PIN, 8'h07);
        reg_rd(ST, 8'h04);
        host_link_model_i.park(1'b0);
        wait_ready(t0);
        check_val("run", 2'b11, {an_en, sw_oe});
        @(posedge clk);
        shdn_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check_val("shutdown", 3'b100, {sout, an_en, sw_oe});
        @(posedge clk);
        shdn_n <= 1'b1;
        wait_ready(t0);
        @(posedge clk);
        speed <= 1'b0;
        host_link_model_i.shift_bits(19, bits);
        check_val("frame", {18'h3ff00, 1'b1}, bits);
        wait_ready(t0);
        host_link_model_i.shift_bits(19, bits);
        check_val("frame", {18'h3ff00, 1'b1}, bits);
        wait_ready(t1);
        check_val("period", SLOW, t1 - t0);
        reg_rd(PIN, 8'h02);
        stop_test();
    end
endmodule
`default_nettype wire
